// ---- verilog/aux_tdm_pkg.sv ----
// Constants for the auxiliary TDM formatter: register map, field layout,
// reset values, slot layout and output select codes.
// Assumes a 16-bit register port and a 20 MHz core clock.
package aux_tdm_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int ADDR_BITS = 16;
  localparam int DATA_BITS = 16;
  localparam logic [15:0] RX_RATE_ADDR = 16'hf606;
  localparam logic [15:0] TX_RATE_ADDR = 16'hf607;
  localparam logic [15:0] AUX_CTRL_ADDR = 16'hf608;
  localparam logic [15:0] AUX_STATUS_ADDR = 16'hf609;
  localparam logic RX_HALVE_RESET = 1'h1;
  localparam logic TX_HALVE_RESET = 1'h1;
  localparam logic [4:0] AUX_CTRL_RESET = 5'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int HALVE_BIT = 0;
  localparam int PIN_SEL_LSB = 0;
  localparam int PIN_SEL_BITS = 4;
  localparam int CLK_SRC_BIT = 4;
  localparam int CTRL_BITS = 5;
  localparam int STAT_HELD_BIT = 0;
  localparam int STAT_ACTIVE_BIT = 1;

  // ----------------------------------------------------------------------
  // Output select codes, one-hot per serial output
  // ----------------------------------------------------------------------
  localparam int OUT_PINS = 4;
  localparam logic [3:0] SEL_OFF = 4'h0;
  localparam logic [3:0] SEL_OUT0 = 4'h1;
  localparam logic [3:0] SEL_OUT1 = 4'h2;
  localparam logic [3:0] SEL_OUT2 = 4'h4;
  localparam logic [3:0] SEL_OUT3 = 4'h8;

  // ----------------------------------------------------------------------
  // TDM frame layout
  // ----------------------------------------------------------------------
  localparam int SLOTS = 8;
  localparam int SLOT_BITS = 32;
  localparam int FRAME_BITS = SLOTS * SLOT_BITS;
  localparam int AUDIO_BITS = 24;
  localparam int AUX_BITS = 4;
  localparam int PAD_BITS = 8;
  localparam int AUX_LEAD = 20;
  localparam int TYPE_LEAD = 22;
  localparam int BLOCK_LEAD = 23;
  localparam int SLOT_LEFT = 0;
  localparam int SLOT_LEFT_AUX = 1;
  localparam int SLOT_TYPE = 2;
  localparam int SLOT_PAD_A = 3;
  localparam int SLOT_RIGHT = 4;
  localparam int SLOT_RIGHT_AUX = 5;
  localparam int SLOT_PAD_B = 6;
  localparam int SLOT_BLOCK = 7;

  // Clock inputs passed through the synchroniser
  localparam int CLK_PINS = 4;

  function automatic int slot_msb(input int k);
    return FRAME_BITS - 1 - k * SLOT_BITS;
  endfunction

endpackage

// ---- verilog/clock_pin_sync.sv ----
// Two-flop synchroniser for the recovered and generated clock pins.
// Assumes the pins are slow against core_clk (several cycles per level).
`timescale 1ns/100ps
module clock_pin_sync (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [aux_tdm_pkg::CLK_PINS-1:0] pin_in,
  output logic [aux_tdm_pkg::CLK_PINS-1:0] pin_sync
);

  // ----------------------------------------------------------------------
  // Per pin stages
  // ----------------------------------------------------------------------
  // The first stage feeds the second only, to keep metastability contained
  genvar i;
  generate
    for (i = 0; i < aux_tdm_pkg::CLK_PINS; i++) begin : g_pin
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge core_clk) begin
        if (rst) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= pin_in[i];
          sync_reg <= meta_reg;
        end
      end
      assign pin_sync[i] = sync_reg;
    end
  endgenerate

endmodule

// ---- verilog/spdif_rx_aux_tdm_output.sv ----
// Auxiliary TDM output of the S/PDIF receiver: register port, working
// clock rate ticks and the eight-slot TDM serialiser.
// Assumes decoded frame data arrive on core_clk with a one-cycle strobe,
// and the TDM clocks are pins sampled through synchronisers.
`timescale 1ns/100ps
module spdif_rx_aux_tdm_output (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [aux_tdm_pkg::ADDR_BITS-1:0] reg_addr,
  input wire logic [aux_tdm_pkg::DATA_BITS-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [aux_tdm_pkg::DATA_BITS-1:0] reg_rdata,
  input wire logic [aux_tdm_pkg::AUDIO_BITS-1:0] rx_left_audio,
  input wire logic [aux_tdm_pkg::AUDIO_BITS-1:0] rx_right_audio,
  input wire logic [aux_tdm_pkg::AUX_BITS-1:0] rx_left_aux,
  input wire logic [aux_tdm_pkg::AUX_BITS-1:0] rx_right_aux,
  input wire logic rx_compr_type,
  input wire logic rx_audio_type,
  input wire logic rx_block_start,
  input wire logic rx_frame_valid,
  input wire logic spdif_bit_clock,
  input wire logic spdif_frame_clock,
  input wire logic gen3_bit_clock,
  input wire logic gen3_frame_clock,
  output logic rx_clock_halve,
  output logic tx_clock_halve,
  output logic rx_clock_tick,
  output logic tx_clock_tick,
  output logic [aux_tdm_pkg::OUT_PINS-1:0] serial_data_output_n,
  output logic [aux_tdm_pkg::OUT_PINS-1:0] serial_output_bit_clock_n,
  output logic [aux_tdm_pkg::OUT_PINS-1:0] serial_output_frame_clock_n
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic rx_halve_reg;
  logic tx_halve_reg;
  logic [aux_tdm_pkg::CTRL_BITS-1:0] ctrl_reg;
  logic [aux_tdm_pkg::DATA_BITS-1:0] rdata_reg;
  logic [aux_tdm_pkg::DATA_BITS-1:0] rdata_next;
  logic phase_reg;
  logic rx_tick_reg;
  logic tx_tick_reg;
  logic [aux_tdm_pkg::AUDIO_BITS-1:0] left_hold_reg;
  logic [aux_tdm_pkg::AUDIO_BITS-1:0] right_hold_reg;
  logic [aux_tdm_pkg::AUX_BITS-1:0] left_aux_reg;
  logic [aux_tdm_pkg::AUX_BITS-1:0] right_aux_reg;
  logic compr_reg;
  logic atype_reg;
  logic block_reg;
  logic held_reg;
  logic [aux_tdm_pkg::CLK_PINS-1:0] pins_sync;
  logic bclk_sel;
  logic lrclk_sel;
  logic bclk_prev_reg;
  logic lrclk_prev_reg;
  logic bclk_fall;
  logic lrclk_rise;
  logic pending_reg;
  logic load_now;
  logic [aux_tdm_pkg::FRAME_BITS-1:0] frame_word;
  logic [aux_tdm_pkg::FRAME_BITS-1:0] shift_reg;
  logic [aux_tdm_pkg::PIN_SEL_BITS-1:0] pin_sel;
  logic clk_src;
  logic tdm_active;
  logic [aux_tdm_pkg::OUT_PINS-1:0] sdata_reg;
  logic [aux_tdm_pkg::OUT_PINS-1:0] bclk_reg;
  logic [aux_tdm_pkg::OUT_PINS-1:0] lrclk_reg;

  function automatic logic [aux_tdm_pkg::SLOT_BITS-1:0] slot_of(
    input logic [aux_tdm_pkg::FRAME_BITS-1:0] f, input int k);
    return f[aux_tdm_pkg::slot_msb(k) -: aux_tdm_pkg::SLOT_BITS];
  endfunction

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_halve_reg <= aux_tdm_pkg::RX_HALVE_RESET;
    end else if (reg_wr && reg_addr == aux_tdm_pkg::RX_RATE_ADDR) begin
      rx_halve_reg <= reg_wdata[aux_tdm_pkg::HALVE_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_halve_reg <= aux_tdm_pkg::TX_HALVE_RESET;
    end else if (reg_wr && reg_addr == aux_tdm_pkg::TX_RATE_ADDR) begin
      tx_halve_reg <= reg_wdata[aux_tdm_pkg::HALVE_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_reg <= aux_tdm_pkg::AUX_CTRL_RESET;
    end else if (reg_wr && reg_addr == aux_tdm_pkg::AUX_CTRL_ADDR) begin
      ctrl_reg <= reg_wdata[aux_tdm_pkg::CTRL_BITS-1:0];
    end
  end

  // Reserved bits read as zero; unmapped addresses read as zero
  always_comb begin
    rdata_next = '0;
    unique case (reg_addr)
      aux_tdm_pkg::RX_RATE_ADDR: begin
        rdata_next[aux_tdm_pkg::HALVE_BIT] = rx_halve_reg;
      end
      aux_tdm_pkg::TX_RATE_ADDR: begin
        rdata_next[aux_tdm_pkg::HALVE_BIT] = tx_halve_reg;
      end
      aux_tdm_pkg::AUX_CTRL_ADDR: begin
        rdata_next[aux_tdm_pkg::CTRL_BITS-1:0] = ctrl_reg;
      end
      aux_tdm_pkg::AUX_STATUS_ADDR: begin
        rdata_next[aux_tdm_pkg::STAT_HELD_BIT] = held_reg;
        rdata_next[aux_tdm_pkg::STAT_ACTIVE_BIT] = tdm_active;
      end
      default: begin
        rdata_next = '0;
      end
    endcase
  end

  // Read data stand for the one cycle after the strobe only
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_reg <= '0;
    end else if (reg_rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= '0;
    end
  end

  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------------
  // Working clock rate ticks
  // ----------------------------------------------------------------------
  // Both ticks share one phase so halved rx and tx stay in step
  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase_reg <= 1'b0;
      rx_tick_reg <= 1'b0;
      tx_tick_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
      rx_tick_reg <= ~rx_halve_reg | phase_reg;
      tx_tick_reg <= ~tx_halve_reg | phase_reg;
    end
  end

  assign rx_clock_halve = rx_halve_reg;
  assign tx_clock_halve = tx_halve_reg;
  assign rx_clock_tick = rx_tick_reg;
  assign tx_clock_tick = tx_tick_reg;

  // ----------------------------------------------------------------------
  // Decoded frame snapshot
  // ----------------------------------------------------------------------
  // One strobe captures every field, so no slot mixes two frames
  always_ff @(posedge core_clk) begin
    if (rst) begin
      left_hold_reg <= '0;
      right_hold_reg <= '0;
      left_aux_reg <= '0;
      right_aux_reg <= '0;
      compr_reg <= 1'b0;
      atype_reg <= 1'b0;
      block_reg <= 1'b0;
      held_reg <= 1'b0;
    end else if (rx_frame_valid) begin
      left_hold_reg <= rx_left_audio;
      right_hold_reg <= rx_right_audio;
      left_aux_reg <= rx_left_aux;
      right_aux_reg <= rx_right_aux;
      compr_reg <= rx_compr_type;
      atype_reg <= rx_audio_type;
      block_reg <= rx_block_start;
      held_reg <= 1'b1;
    end
  end

  always_comb begin
    frame_word = '0;
    frame_word[aux_tdm_pkg::slot_msb(aux_tdm_pkg::SLOT_LEFT)
      -: aux_tdm_pkg::SLOT_BITS] =
      {left_hold_reg, {aux_tdm_pkg::PAD_BITS{1'b0}}};
    frame_word[aux_tdm_pkg::slot_msb(aux_tdm_pkg::SLOT_LEFT_AUX)
      -: aux_tdm_pkg::SLOT_BITS] = {{aux_tdm_pkg::AUX_LEAD{1'b0}},
      left_aux_reg, {aux_tdm_pkg::PAD_BITS{1'b0}}};
    frame_word[aux_tdm_pkg::slot_msb(aux_tdm_pkg::SLOT_TYPE)
      -: aux_tdm_pkg::SLOT_BITS] = {{aux_tdm_pkg::TYPE_LEAD{1'b0}},
      compr_reg, atype_reg, {aux_tdm_pkg::PAD_BITS{1'b0}}};
    frame_word[aux_tdm_pkg::slot_msb(aux_tdm_pkg::SLOT_RIGHT)
      -: aux_tdm_pkg::SLOT_BITS] =
      {right_hold_reg, {aux_tdm_pkg::PAD_BITS{1'b0}}};
    frame_word[aux_tdm_pkg::slot_msb(aux_tdm_pkg::SLOT_RIGHT_AUX)
      -: aux_tdm_pkg::SLOT_BITS] = {{aux_tdm_pkg::AUX_LEAD{1'b0}},
      right_aux_reg, {aux_tdm_pkg::PAD_BITS{1'b0}}};
    frame_word[aux_tdm_pkg::slot_msb(aux_tdm_pkg::SLOT_BLOCK)
      -: aux_tdm_pkg::SLOT_BITS] = {{aux_tdm_pkg::BLOCK_LEAD{1'b0}},
      block_reg, {aux_tdm_pkg::PAD_BITS{1'b0}}};
  end

  // ----------------------------------------------------------------------
  // TDM clock selection and serialiser
  // ----------------------------------------------------------------------
  clock_pin_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in({gen3_frame_clock, gen3_bit_clock,
             spdif_frame_clock, spdif_bit_clock}),
    .pin_sync(pins_sync)
  );

  assign pin_sel = ctrl_reg[aux_tdm_pkg::PIN_SEL_LSB +:
                            aux_tdm_pkg::PIN_SEL_BITS];
  assign clk_src = ctrl_reg[aux_tdm_pkg::CLK_SRC_BIT];
  // Illegal codes with several bits set are treated as off
  assign tdm_active = (pin_sel == aux_tdm_pkg::SEL_OUT0) ||
                      (pin_sel == aux_tdm_pkg::SEL_OUT1) ||
                      (pin_sel == aux_tdm_pkg::SEL_OUT2) ||
                      (pin_sel == aux_tdm_pkg::SEL_OUT3);
  // Generator 3 must already run from the receiver reference
  assign bclk_sel = clk_src ? pins_sync[2] : pins_sync[0];
  assign lrclk_sel = clk_src ? pins_sync[3] : pins_sync[1];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bclk_prev_reg <= 1'b0;
      lrclk_prev_reg <= 1'b0;
    end else begin
      bclk_prev_reg <= bclk_sel;
      lrclk_prev_reg <= lrclk_sel;
    end
  end

  assign bclk_fall = bclk_prev_reg & ~bclk_sel;
  assign lrclk_rise = ~lrclk_prev_reg & lrclk_sel;
  assign load_now = pending_reg | lrclk_rise;

  // A frame clock rise in the same cycle as the load still counts
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pending_reg <= 1'b0;
    end else if (bclk_fall) begin
      pending_reg <= 1'b0;
    end else if (lrclk_rise) begin
      pending_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      shift_reg <= '0;
    end else if (bclk_fall && load_now) begin
      shift_reg <= frame_word;
    end else if (bclk_fall) begin
      shift_reg <= {shift_reg[aux_tdm_pkg::FRAME_BITS-2:0], 1'b0};
    end
  end

  // Only the one selected port is driven; all others stay low
  genvar p;
  generate
    for (p = 0; p < aux_tdm_pkg::OUT_PINS; p++) begin : g_out
      always_ff @(posedge core_clk) begin
        if (rst) begin
          sdata_reg[p] <= 1'b0;
          bclk_reg[p] <= 1'b0;
          lrclk_reg[p] <= 1'b0;
        end else if (tdm_active && pin_sel[p]) begin
          sdata_reg[p] <=
            shift_reg[aux_tdm_pkg::FRAME_BITS-1];
          bclk_reg[p] <= bclk_sel;
          lrclk_reg[p] <= lrclk_sel;
        end else begin
          sdata_reg[p] <= 1'b0;
          bclk_reg[p] <= 1'b0;
          lrclk_reg[p] <= 1'b0;
        end
      end
    end
  endgenerate

  assign serial_data_output_n = sdata_reg;
  assign serial_output_bit_clock_n = bclk_reg;
  assign serial_output_frame_clock_n = lrclk_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_rx_half_rate: assert property (@(posedge core_clk) disable iff (rst)
    $past(rx_halve_reg) && rx_halve_reg && rx_clock_tick |=> !rx_clock_tick)
    else $error("rx tick not halved");
  a_rx_full_rate: assert property (@(posedge core_clk) disable iff (rst)
    !rx_halve_reg |=> rx_clock_tick)
    else $error("rx tick missing at full rate");
  a_tx_rate_pick: assert property (@(posedge core_clk) disable iff (rst)
    tx_clock_tick == (!$past(tx_halve_reg) || $past(phase_reg)))
    else $error("tx tick wrong for rate select");
  a_rate_reset_one: assert property (@(posedge core_clk) disable iff (rst)
    $past(rst) |-> rx_halve_reg && tx_halve_reg)
    else $error("rate selects not one after reset");
  a_serial_msb_out: assert property (@(posedge core_clk) disable iff (rst)
    tdm_active && $stable(pin_sel) |=>
    (|serial_data_output_n) == $past(shift_reg[aux_tdm_pkg::FRAME_BITS-1]))
    else $error("serial data not the frame msb");
  a_left_slot: assert property (@(posedge core_clk) disable iff (rst)
    bclk_fall && load_now |=> slot_of(shift_reg, aux_tdm_pkg::SLOT_LEFT) ==
    {$past(left_hold_reg), {aux_tdm_pkg::PAD_BITS{1'b0}}})
    else $error("left audio slot wrong");
  a_left_aux_slot: assert property (@(posedge core_clk) disable iff (rst)
    bclk_fall && load_now |=> slot_of(shift_reg, aux_tdm_pkg::SLOT_LEFT_AUX)
    == {{aux_tdm_pkg::AUX_LEAD{1'b0}}, $past(left_aux_reg),
        {aux_tdm_pkg::PAD_BITS{1'b0}}})
    else $error("left aux slot wrong");
  a_type_slot: assert property (@(posedge core_clk) disable iff (rst)
    bclk_fall && load_now |=> slot_of(shift_reg, aux_tdm_pkg::SLOT_TYPE) ==
    {{aux_tdm_pkg::TYPE_LEAD{1'b0}}, $past(compr_reg), $past(atype_reg),
     {aux_tdm_pkg::PAD_BITS{1'b0}}})
    else $error("type slot wrong");
  a_zero_slots: assert property (@(posedge core_clk) disable iff (rst)
    bclk_fall && load_now |=>
    slot_of(shift_reg, aux_tdm_pkg::SLOT_PAD_A) == '0 &&
    slot_of(shift_reg, aux_tdm_pkg::SLOT_PAD_B) == '0)
    else $error("zero slots not zero");
  a_right_slot: assert property (@(posedge core_clk) disable iff (rst)
    bclk_fall && load_now |=> slot_of(shift_reg, aux_tdm_pkg::SLOT_RIGHT) ==
    {$past(right_hold_reg), {aux_tdm_pkg::PAD_BITS{1'b0}}})
    else $error("right audio slot wrong");
  a_right_aux_slot: assert property (@(posedge core_clk) disable iff (rst)
    bclk_fall && load_now |=> slot_of(shift_reg, aux_tdm_pkg::SLOT_RIGHT_AUX)
    == {{aux_tdm_pkg::AUX_LEAD{1'b0}}, $past(right_aux_reg),
        {aux_tdm_pkg::PAD_BITS{1'b0}}})
    else $error("right aux slot wrong");
  a_block_slot: assert property (@(posedge core_clk) disable iff (rst)
    bclk_fall && load_now |=> slot_of(shift_reg, aux_tdm_pkg::SLOT_BLOCK) ==
    {{aux_tdm_pkg::BLOCK_LEAD{1'b0}}, $past(block_reg),
     {aux_tdm_pkg::PAD_BITS{1'b0}}})
    else $error("block start slot wrong");
  a_one_port_only: assert property (@(posedge core_clk) disable iff (rst)
    tdm_active |=> ((serial_output_bit_clock_n | serial_output_frame_clock_n
    | serial_data_output_n) & ~$past(pin_sel)) == '0)
    else $error("unselected port driven");
  a_disabled_quiet: assert property (@(posedge core_clk) disable iff (rst)
    !tdm_active |=> serial_data_output_n == '0 &&
    serial_output_bit_clock_n == '0 && serial_output_frame_clock_n == '0)
    else $error("output active while disabled");
  a_clock_source: assert property (@(posedge core_clk) disable iff (rst)
    tdm_active |=> (|serial_output_bit_clock_n) ==
    ($past(clk_src) ? $past(pins_sync[2]) : $past(pins_sync[0])))
    else $error("bit clock from wrong source");
  a_one_frame_snap: assert property (@(posedge core_clk) disable iff (rst)
    rx_frame_valid |=> left_hold_reg == $past(rx_left_audio) &&
    right_hold_reg == $past(rx_right_audio) && block_reg ==
    $past(rx_block_start))
    else $error("snapshot fields not from one frame");

  c_load_recovered: cover property (@(posedge core_clk) disable iff (rst)
    bclk_fall && load_now && tdm_active && !clk_src);
  c_load_generator: cover property (@(posedge core_clk) disable iff (rst)
    bclk_fall && load_now && tdm_active && clk_src);
  c_frame_then_load: cover property (@(posedge core_clk) disable iff (rst)
    rx_frame_valid ##[1:200] (bclk_fall && load_now));
  c_rate_change: cover property (@(posedge core_clk) disable iff (rst)
    $fell(rx_halve_reg));

endmodule

// ---- tb/tdm_frame_receiver.sv ----
// Downstream TDM receiver model watching one serial output port.
// Assumes data settle one core cycle after the output bit clock falls.
`timescale 1ns/100ps
module tdm_frame_receiver (
  input wire logic bit_clock,
  input wire logic frame_clock,
  input wire logic serial_data,
  output logic [255:0] frame_word,
  output logic [15:0] frame_count
);
  // ----------------------------------------------------------------------
  // Frame capture
  // ----------------------------------------------------------------------
  logic [255:0] shift_reg;
  logic frame_seen;
  initial begin
    shift_reg = '0;
    frame_seen = 1'b0;
    frame_word = '0;
    frame_count = '0;
  end
  // Frame clock taken on the fall, where it cannot race the bit clock
  always @(negedge bit_clock) begin
    frame_seen <= frame_clock;
  end
  // Eight slots of 32 bits, msb first, close on the rise after a fall that sees the frame clock high
  always @(posedge bit_clock) begin
    if (frame_seen) begin
      frame_word <= shift_reg;
      frame_count <= frame_count + 16'h1;
    end
    shift_reg = {shift_reg[254:0], serial_data};
  end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the auxiliary TDM output block.
// Assumes the bench plays software, the decoder and the TDM clock pins.
`timescale 1ns/100ps
module tb;
  // ----------------------------------------------------------------------
  // Stimulus, model and checks
  // ----------------------------------------------------------------------
  logic core_clk, rst, reg_wr, reg_rd, c_type, a_type, blk, fvalid, src;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, rcv_count;
  logic [23:0] l_aud, r_aud;
  logic [3:0] l_aux, r_aux, sdo, sbclk, sfclk, mask;
  logic sp_b, sp_f, g3_b, g3_f, rx_h, tx_h, rx_t, tx_t;
  logic [255:0] rcv_word, pend_exp;
  logic [255:0] exp_q[$];
  logic [15:0] wr_v[6] = '{16'h0001, 16'h0012, 16'h0004, 16'h0018,
    16'h0000, 16'hffff};
  int n_fail, samples_checked, port, seed;

  spdif_rx_aux_tdm_output spdif_rx_aux_tdm_output_inst (.core_clk(core_clk),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_left_audio(l_aud),
    .rx_right_audio(r_aud), .rx_left_aux(l_aux), .rx_right_aux(r_aux),
    .rx_compr_type(c_type), .rx_audio_type(a_type), .rx_block_start(blk),
    .rx_frame_valid(fvalid), .spdif_bit_clock(sp_b),
    .spdif_frame_clock(sp_f), .gen3_bit_clock(g3_b),
    .gen3_frame_clock(g3_f), .rx_clock_halve(rx_h), .tx_clock_halve(tx_h),
    .rx_clock_tick(rx_t), .tx_clock_tick(tx_t), .serial_data_output_n(sdo),
    .serial_output_bit_clock_n(sbclk), .serial_output_frame_clock_n(sfclk));
  tdm_frame_receiver tdm_frame_receiver_inst (.bit_clock(sbclk[port]),
    .frame_clock(sfclk[port]), .serial_data(sdo[port]),
    .frame_word(rcv_word), .frame_count(rcv_count));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic cmp_reg(string what, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (e !== g) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp_frame(logic [255:0] e, logic [255:0] g);
    samples_checked++;
    if (e !== g) begin
      n_fail++;
      $display("mismatch tdm_frame expected %h seen %h", e, g);
    end
  endtask

  task automatic reg_write(logic [15:0] a, logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_check(logic [15:0] a, logic [15:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 cmp_reg("reg_rdata", e, reg_rdata);
  endtask

  task automatic tick_check(logic rh, logic th);
    logic [15:0] nr, nt;
    nr = 16'h0;
    nt = 16'h0;
    repeat (8) begin
      @(posedge core_clk);
      #1 nr = nr + 16'(rx_t);
      nt = nt + 16'(tx_t);
    end
    cmp_reg("rx_clock_halve", 16'(rh), 16'(rx_h));
    cmp_reg("tx_clock_halve", 16'(th), 16'(tx_h));
    cmp_reg("rx_clock_tick", rh ? 16'h4 : 16'h8, nr);
    cmp_reg("tx_clock_tick", th ? 16'h4 : 16'h8, nt);
  endtask

  // Decoded frame: random fields, one strobe, expected slot image
  task automatic send_data();
    @(posedge core_clk);
    l_aud <= 24'($random(seed));
    r_aud <= 24'($random(seed));
    {l_aux, r_aux, c_type, a_type, blk} <= 11'($random(seed));
    fvalid <= 1'b1;
    @(posedge core_clk);
    fvalid <= 1'b0;
    pend_exp = {l_aud, 8'h00, 20'h0, l_aux, 8'h00, 22'h0, c_type, a_type,
      8'h00, 32'h0, r_aud, 8'h00, 20'h0, r_aux, 8'h00, 32'h0, 23'h0, blk,
      8'h00};
  endtask

  // Unused clock pair carries inverted clocks so a wrong pick garbles
  task automatic pins(logic b, logic f);
    g3_b <= src ? b : ~b;
    g3_f <= src ? f : ~f;
    sp_b <= src ? ~b : b;
    sp_f <= src ? ~f : f;
  endtask

  // One TDM frame; new decoded data arrive mid-frame for the next one
  task automatic run_frame(logic push);
    logic [255:0] cur;
    cur = pend_exp;
    @(posedge core_clk);
    for (int i = 0; i < 256; i++) begin
      pins(1'b1, i == 0);
      repeat (4) @(posedge core_clk);
      pins(1'b0, i == 0);
      #1 cmp_reg("out_pins", {4'h0, mask, (i == 0) ? mask : 4'h0},
        {sdo & ~mask, sbclk, sfclk});
      if (i == 100) send_data();
      else repeat (2) @(posedge core_clk);
      repeat (2) @(posedge core_clk);
    end
    if (push) exp_q.push_back(cur);
  endtask

  always @(rcv_count) begin
    #1 if (exp_q.size() > 0) cmp_frame(exp_q.pop_front(), rcv_word);
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    n_fail++;
    final_report();
  end

  initial begin
    seed = 32'h12fe8103;
    {rst, reg_wr, reg_rd, fvalid, src} = 5'h10;
    {reg_addr, reg_wdata, l_aud, r_aud, l_aux, r_aux} = '0;
    {c_type, a_type, blk, sp_b, sp_f, g3_b, g3_f} = 7'h0;
    {port, mask, n_fail, samples_checked} = '0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    reg_check(16'hf606, 16'h0001);
    reg_check(16'hf607, 16'h0001);
    reg_check(16'hf608, 16'h0000);
    reg_check(16'hf60a, 16'h0000);
    reg_check(16'hf609, 16'h0000);
    tick_check(1'b1, 1'b1);
    $display("test register_reset done");
    for (int j = 0; j < 4; j++) begin
      reg_write(16'hf606, {15'h7fff, j[0]});
      reg_write(16'hf607, {15'h7fff, j[1]});
      reg_check(16'hf606, 16'(j[0]));
      reg_check(16'hf607, 16'(j[1]));
      tick_check(j[0], j[1]);
    end
    $display("test clock_rates done");
    send_data();
    for (int k = 0; k < 6; k++) begin
      // Chosen port is taken as clock master by the bench; generator 3
      // set-up lives outside this block, so its clocks come straight in
      reg_write(16'hf608, wr_v[k]);
      reg_check(16'hf608, wr_v[k] & 16'h001f);
      reg_check(16'hf609, {14'h0, k < 4, 1'b1});
      src = wr_v[k][4];
      mask = (k < 4) ? 4'(1 << k) : 4'h0;
      if (k < 4) port = k;
      run_frame(k < 4);
      run_frame(k < 4);
      run_frame(1'b0);
      $display("test output_code %0d done", k);
    end
    cmp_reg("pending_frames", 16'h0, 16'(exp_q.size()));
    final_report();
  end
endmodule
